// *** core/adc_seq_params.svh ***
// Constants of the multichannel converter sequencer.
// Assumes inclusion by bare name from the core/ files.
`ifndef ADC_SEQ_PARAMS_SVH
`define ADC_SEQ_PARAMS_SVH

// ----------------------------------------
// Register map (byte addresses)
// ----------------------------------------
`define ADDR_W 12
`define REG_CTRL 12'h000
`define REG_STATUS 12'h004
`define REG_SCANS 12'h008
`define REG_LIMIT 12'h00C

// ----------------------------------------
// Field positions
// ----------------------------------------
`define CTRL_START_BIT 0
`define CTRL_CLEAR_BIT 1
`define ST_LATCH_BIT 0
`define ST_ACTIVE_BIT 1
`define ST_EOC_BIT 2
`define ST_BUSY_BIT 3
`define ST_CHAN_LO 4
`define ST_STEP_LO 8

// ----------------------------------------
// Fixed values
// ----------------------------------------
`define LAST_CHANNEL 4'hF
`define CHAN_FIRST 4'h0
`define CHAN_ONE 4'h1
`define SCANS_ONE 16'h0001
`define SCANS_ZERO 16'h0000
`define DATA_ZERO 32'h0000_0000

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_HZ 10000000
`define SETTLE_NS 3500
`define SETTLE_CYC ((`SETTLE_NS * (`CLK_HZ / 1000000) + 999) / 1000)
`define SETTLE_CNT_W 6

`endif

// *** core/adc_seq_pkg.sv ***
// Types shared by the sequencer files.
// Assumes nothing beyond a SystemVerilog compiler.
package adc_seq_pkg;

   // Step register codes; 9, B, D and F are never used
   typedef enum logic [3:0] {
      STEP_IDLE = 4'h0,
      STEP_WAIT = 4'h1,
      STEP_MSB = 4'h2,
      STEP_CHK = 4'h3,
      STEP_SELLO = 4'h4,
      STEP_LSB = 4'h5,
      STEP_HOLD1 = 4'h6,
      STEP_HOLD2 = 4'h7,
      STEP_DONE = 4'h8,
      STEP_PADA = 4'hA,
      STEP_PADC = 4'hC,
      STEP_LAST = 4'hE
   } step_t;

endpackage

// *** core/apb_reg_port.sv ***
// APB slave handshake with a registered pready.
// Assumes a compliant APB master on sys_clk.
`timescale 1ns/1ps
`include "adc_seq_params.svh"

module apb_reg_port
   import adc_seq_pkg::*;
(
   // Clock, reset, enable
   input wire logic sys_clk,
   input wire logic rstSync_b,
   input wire logic clkEn,
   // APB request
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   // Transfer strobes
   output logic accStart,
   output logic wrCommit,
   output logic pready
);

   logic pready_q;

   // Second access cycle answers; the request stands until then
   assign accStart = psel && penable && !pready_q;
   assign wrCommit = psel && penable && pready_q && pwrite;
   assign pready = pready_q;

   always_ff @(posedge sys_clk or negedge rstSync_b) begin
      if (!rstSync_b) begin
         pready_q <= 1'b0;
      end else if (clkEn) begin
         pready_q <= accStart;
      end
   end

endmodule // apb_reg_port

// *** core/multichannel_adc_sequencer.sv ***
// Scan sequencer for a multiplexed converter feeding a byte FIFO.
// Assumes converter, mux and FIFO outside; busy rises within one cycle of convert.
`timescale 1ns/1ps
`include "adc_seq_params.svh"

module multichannel_adc_sequencer
   import adc_seq_pkg::*;
(
   // Clock, reset, enable
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic clkEn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [`ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Converter and multiplexer
   input wire logic converter_busy,
   output logic [3:0] channelSel,
   output logic convertStart,
   output logic byteSelLow,
   // Result FIFO
   output logic result_fifo_write,
   // Completion and LED
   output logic eocFlag,
   output logic ledSideA,
   output logic ledSideB
);

   // ----------------------------------------
   // Reset release
   // ----------------------------------------
   logic rstMeta_q;
   logic rstSync_q;

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         rstMeta_q <= 1'b0;
         rstSync_q <= 1'b0;
      end else begin
         rstMeta_q <= 1'b1;
         rstSync_q <= rstMeta_q;
      end
   end

   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   step_t step_q;
   step_t step_d;
   logic [3:0] chan_q;
   logic startLatch_q;
   logic convert_q;
   logic fifoWr_q;
   logic byteSel_q;
   logic eoc_q;
   logic ledA_q;
   logic ledB_q;
   logic scanDone_q;
   logic [15:0] scans_q;
   logic [31:0] prdata_q;
   logic pslverr_q;
   logic accStart;
   logic wrCommit;
   logic settled;
   logic startWrite;
   logic clearWrite;
   logic takeStart;
   logic chanInc;
   logic lastSeen;
   logic toggleEoc;

   // ----------------------------------------
   // Address decode
   // ----------------------------------------
   function automatic logic isMapped(input logic [`ADDR_W-1:0] a);
      isMapped = (a == `REG_CTRL) || (a == `REG_STATUS) ||
                 (a == `REG_SCANS) || (a == `REG_LIMIT);
   endfunction

   function automatic logic hits(input logic [`ADDR_W-1:0] a, input logic [`ADDR_W-1:0] r);
      hits = (a == r);
   endfunction

   // ----------------------------------------
   // Bus handshake
   // ----------------------------------------
   apb_reg_port u_port (
      .sys_clk(sys_clk),
      .rstSync_b(rstSync_q),
      .clkEn(clkEn),
      .psel(psel),
      .penable(penable),
      .pwrite(pwrite),
      .accStart(accStart),
      .wrCommit(wrCommit),
      .pready(pready)
   );

   assign startWrite = wrCommit && hits(paddr, `REG_CTRL) && pwdata[`CTRL_START_BIT];
   assign clearWrite = wrCommit && hits(paddr, `REG_CTRL) && pwdata[`CTRL_CLEAR_BIT];

   // ----------------------------------------
   // Read data and error
   // ----------------------------------------
   always_ff @(posedge sys_clk or negedge rstSync_q) begin
      if (!rstSync_q) begin
         prdata_q <= `DATA_ZERO;
         pslverr_q <= 1'b0;
      end else if (clkEn) begin
         if (accStart) begin
            pslverr_q <= !isMapped(paddr);
            prdata_q <= `DATA_ZERO;
            if (!pwrite) begin
               if (hits(paddr, `REG_STATUS)) begin
                  prdata_q[`ST_LATCH_BIT] <= startLatch_q;
                  prdata_q[`ST_ACTIVE_BIT] <= (step_q != STEP_IDLE);
                  prdata_q[`ST_EOC_BIT] <= eoc_q;
                  prdata_q[`ST_BUSY_BIT] <= converter_busy;
                  prdata_q[`ST_CHAN_LO +: 4] <= chan_q;
                  prdata_q[`ST_STEP_LO +: 4] <= step_q;
               end else if (hits(paddr, `REG_SCANS)) begin
                  prdata_q[15:0] <= scans_q;
               end else if (hits(paddr, `REG_LIMIT)) begin
                  prdata_q[3:0] <= `LAST_CHANNEL;
               end
            end
         end else begin
            pslverr_q <= 1'b0;
         end
      end
   end

   assign prdata = prdata_q;
   assign pslverr = pslverr_q;

   // ----------------------------------------
   // Start request latch
   // ----------------------------------------
   // Waits out settling after reset or a channel change
   assign takeStart = (step_q == STEP_IDLE) && startLatch_q && settled;

   always_ff @(posedge sys_clk or negedge rstSync_q) begin
      if (!rstSync_q) begin
         startLatch_q <= 1'b0;
      end else if (clkEn) begin
         if (startWrite) begin
            startLatch_q <= 1'b1;
         end else if (takeStart || clearWrite) begin
            startLatch_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Step register
   // ----------------------------------------
   always_comb begin
      step_d = step_q;
      unique case (step_q)
         STEP_IDLE: begin
            if (takeStart) begin
               step_d = STEP_WAIT;
            end
         end
         STEP_WAIT: begin
            if (!converter_busy && !convert_q) begin
               step_d = STEP_MSB;
            end
         end
         STEP_MSB: step_d = STEP_CHK;
         STEP_CHK: step_d = STEP_SELLO;
         STEP_SELLO: step_d = STEP_LSB;
         STEP_LSB: step_d = STEP_HOLD1;
         STEP_HOLD1: step_d = STEP_HOLD2;
         STEP_HOLD2: step_d = STEP_DONE;
         STEP_DONE: step_d = STEP_PADA;
         STEP_PADA: step_d = STEP_PADC;
         STEP_PADC: step_d = STEP_LAST;
         STEP_LAST: begin
            // First channel settles before idle, a queued start may follow at once
            if (settled && scanDone_q) begin
               step_d = STEP_IDLE;
            end else if (settled) begin
               step_d = STEP_WAIT;
            end
         end
         default: step_d = STEP_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk or negedge rstSync_q) begin
      if (!rstSync_q) begin
         step_q <= STEP_IDLE;
      end else if (clkEn) begin
         step_q <= step_d;
      end
   end

   // ----------------------------------------
   // Settling time
   // ----------------------------------------
   assign chanInc = (step_q == STEP_MSB);

   settle_timer u_settle (
      .sys_clk(sys_clk),
      .rstSync_b(rstSync_q),
      .clkEn(clkEn),
      .restart(chanInc),
      .settled(settled)
   );

   // ----------------------------------------
   // Channel counter
   // ----------------------------------------
   assign lastSeen = (chan_q == 4'(`LAST_CHANNEL + `CHAN_ONE));

   always_ff @(posedge sys_clk or negedge rstSync_q) begin
      if (!rstSync_q) begin
         chan_q <= `CHAN_FIRST;
      end else if (clkEn) begin
         if (chanInc) begin
            chan_q <= chan_q + `CHAN_ONE;
         end else if ((step_q == STEP_CHK) && lastSeen) begin
            chan_q <= `CHAN_FIRST;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rstSync_q) begin
      if (!rstSync_q) begin
         scanDone_q <= 1'b0;
      end else if (clkEn) begin
         if ((step_q == STEP_CHK) && lastSeen) begin
            scanDone_q <= 1'b1;
         end else if (step_q == STEP_IDLE) begin
            scanDone_q <= 1'b0;
         end
      end
   end

   assign channelSel = chan_q;

   // ----------------------------------------
   // Conversion start
   // ----------------------------------------
   always_ff @(posedge sys_clk or negedge rstSync_q) begin
      if (!rstSync_q) begin
         convert_q <= 1'b0;
      end else if (clkEn) begin
         convert_q <= takeStart ||
                      ((step_q == STEP_LAST) && !scanDone_q && settled);
      end
   end

   assign convertStart = convert_q;

   // ----------------------------------------
   // FIFO strobe and byte select
   // ----------------------------------------
   always_ff @(posedge sys_clk or negedge rstSync_q) begin
      if (!rstSync_q) begin
         fifoWr_q <= 1'b0;
      end else if (clkEn) begin
         fifoWr_q <= (step_q == STEP_MSB) || (step_q == STEP_LSB);
      end
   end

   always_ff @(posedge sys_clk or negedge rstSync_q) begin
      if (!rstSync_q) begin
         byteSel_q <= 1'b0;
      end else if (clkEn) begin
         if (step_q == STEP_SELLO) begin
            byteSel_q <= 1'b1;
         end else if (step_q == STEP_DONE) begin
            byteSel_q <= 1'b0;
         end
      end
   end

   assign result_fifo_write = fifoWr_q;
   assign byteSelLow = byteSel_q;

   // ----------------------------------------
   // Completion flag and LED
   // ----------------------------------------
   assign toggleEoc = (step_q == STEP_DONE) && scanDone_q;

   always_ff @(posedge sys_clk or negedge rstSync_q) begin
      if (!rstSync_q) begin
         eoc_q <= 1'b0;
         ledA_q <= 1'b0;
         ledB_q <= 1'b1;
      end else if (clkEn) begin
         if (toggleEoc) begin
            eoc_q <= !eoc_q;
            ledA_q <= !eoc_q;
            ledB_q <= eoc_q;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rstSync_q) begin
      if (!rstSync_q) begin
         scans_q <= `SCANS_ZERO;
      end else if (clkEn) begin
         if (toggleEoc) begin
            scans_q <= scans_q + `SCANS_ONE;
         end
      end
   end

   assign eocFlag = eoc_q;
   assign ledSideA = ledA_q;
   assign ledSideB = ledB_q;

endmodule // multichannel_adc_sequencer

// *** core/settle_timer.sv ***
// Counts settling cycles after a channel change.
// Assumes restart is a one-cycle pulse in the sys_clk domain.
`timescale 1ns/1ps
`include "adc_seq_params.svh"

module settle_timer
   import adc_seq_pkg::*;
(
   // Clock, reset, enable
   input wire logic sys_clk,
   input wire logic rstSync_b,
   input wire logic clkEn,
   // Control
   input wire logic restart,
   output logic settled
);

   logic [`SETTLE_CNT_W-1:0] count_q;

   always_ff @(posedge sys_clk or negedge rstSync_b) begin
      if (!rstSync_b) begin
         count_q <= '0;
      end else if (clkEn) begin
         if (restart) begin
            count_q <= '0;
         end else if (count_q != `SETTLE_CNT_W'(`SETTLE_CYC)) begin
            count_q <= count_q + `SETTLE_CNT_W'(1);
         end
      end
   end

   // Reached after the full settling count
   assign settled = (count_q == `SETTLE_CNT_W'(`SETTLE_CYC));

endmodule // settle_timer

// *** test/adc_far_side.sv ***
// Converter, channel mux and byte FIFO model.
// Assumes convertStart is a one-cycle pulse; conversion length set by convLen.
`timescale 1ns/1ps

module adc_far_side (
   // Clock
   input wire logic sys_clk,
   // Converter and mux
   input wire logic convertStart,
   input wire logic [3:0] channelSel,
   input wire logic byteSelLow,
   input wire logic [5:0] convLen,
   output logic converter_busy,
   // FIFO
   input wire logic result_fifo_write
);
   logic [5:0] busyCnt_q = 6'h00;
   logic [15:0] result_q = 16'h0000;
   logic [7:0] fifoMem[$];
   // Result pattern marks the channel that was routed at start
   always_ff @(posedge sys_clk) begin
      if (convertStart) begin
         busyCnt_q <= convLen;
         result_q <= {4'hA, channelSel, 4'h5, ~channelSel};
      end else if (busyCnt_q != 6'h00) begin
         busyCnt_q <= busyCnt_q - 6'h01;
      end
      if (result_fifo_write) begin
         fifoMem.push_back(byteSelLow ? result_q[7:0] : result_q[15:8]);
      end
   end
   assign converter_busy = (busyCnt_q != 6'h00);
endmodule // adc_far_side

// *** test/seq_port_properties.sv ***
// Port checker for the scan sequencer.
// Assumes it is bound into multichannel_adc_sequencer.
`timescale 1ns/1ps

module seq_port_checker (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // Watched ports
   input wire logic converter_busy,
   input wire logic [3:0] channelSel,
   input wire logic convertStart,
   input wire logic byteSelLow,
   input wire logic result_fifo_write,
   input wire logic eocFlag,
   input wire logic ledSideA,
   input wire logic ledSideB
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   // ------------------------------
   // Sequencing properties
   // ------------------------------
   a_busy_blocks_store: assert property (result_fifo_write |-> !converter_busy)
      else $error("byte stored while converter busy");
   a_conv_then_store: assert property ($rose(convertStart) |=> !convertStart ##[1:200] result_fifo_write)
      else $error("no store after conversion start");
   a_msb_then_lsb: assert property (result_fifo_write && !byteSelLow |=>
      !result_fifo_write ##[1:8] (result_fifo_write && byteSelLow))
      else $error("low byte store missing after high byte");
   a_byte_outlasts: assert property (result_fifo_write && byteSelLow |=> byteSelLow)
      else $error("byte select fell with strobe");
   a_settle_gap: assert property ($changed(channelSel) |-> !convertStart [*8] ##1 !convertStart)
      else $error("conversion started before settling");
   a_chan_step: assert property ($changed(channelSel) && channelSel != 4'h0 |->
      channelSel == $past(channelSel) + 4'h1)
      else $error("channel counter skipped");
   a_eoc_first_chan: assert property ($changed(eocFlag) |-> channelSel == 4'h0)
      else $error("completion with channel not cleared");
   a_idle_after: assert property ($changed(eocFlag) |-> !convertStart [*8])
      else $error("conversion right after completion");
   a_led_pair: assert property ((ledSideA == eocFlag) && (ledSideB != eocFlag))
      else $error("led sides not flag and inverse");
   c_low_store: cover property (result_fifo_write && byteSelLow);
   c_scan_done: cover property ($changed(eocFlag));
   c_conv: cover property (convertStart);
endmodule // seq_port_checker

bind multichannel_adc_sequencer seq_port_checker i_seq_port_checker (.sys_clk(sys_clk), .rst_b(rst_b),
   .converter_busy(converter_busy), .channelSel(channelSel), .convertStart(convertStart),
   .byteSelLow(byteSelLow), .result_fifo_write(result_fifo_write), .eocFlag(eocFlag),
   .ledSideA(ledSideA), .ledSideB(ledSideB));

// *** test/tb.sv ***
// Self-checking bench for the scan sequencer.
// Assumes core/ on the include path and the far-side model and checker compiled.
`timescale 1ns/1ps
`include "adc_seq_params.svh"

module tb;
   logic sys_clk, rst_b, clkEn, psel, penable, pwrite, pready, pslverr, converter_busy;
   logic [`ADDR_W-1:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0] channelSel;
   logic convertStart, byteSelLow, result_fifo_write, eocFlag, ledSideA, ledSideB;
   logic [5:0] convLen;
   int badCount = 0;
   int samplesChecked = 0;

   multichannel_adc_sequencer i_multichannel_adc_sequencer (.sys_clk(sys_clk), .rst_b(rst_b),
      .clkEn(clkEn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .converter_busy(converter_busy),
      .channelSel(channelSel), .convertStart(convertStart), .byteSelLow(byteSelLow),
      .result_fifo_write(result_fifo_write), .eocFlag(eocFlag), .ledSideA(ledSideA), .ledSideB(ledSideB));
   adc_far_side i_adc_far_side (.sys_clk(sys_clk), .convertStart(convertStart), .channelSel(channelSel),
      .byteSelLow(byteSelLow), .convLen(convLen), .converter_busy(converter_busy),
      .result_fifo_write(result_fifo_write));

   // ------------------------------
   // Shared tasks
   // ------------------------------
   task automatic chk(input logic ok, input string msg);
      samplesChecked++;
      if (ok !== 1'b1) begin
         badCount++;
         $display("BAD %0t %s", $time, msg);
      end
   endtask

   task automatic stop_test();
      $display("TB: checks %0d mismatches %0d", samplesChecked, badCount);
      if (badCount == 0 && samplesChecked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic do_reset();
      rst_b <= 1'b0;
      repeat (12) @(posedge sys_clk);
      rst_b <= 1'b1;
      repeat (3) @(posedge sys_clk);
   endtask

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic err);
      int n;
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      chk(n < 20, "no bus answer");
      r = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // ------------------------------
   // Scenarios
   // ------------------------------
   task automatic reset_values();
      logic [31:0] r;
      logic err;
      chk(channelSel === 4'h0 && eocFlag === 1'b0 && ledSideB === 1'b1, "reset outputs");
      apb(1'b1, `REG_LIMIT, 32'h0000_0000, r, err);
      apb(1'b0, `REG_LIMIT, 32'h0000_0000, r, err);
      chk(r === 32'h0000_000F && err === 1'b0, "last channel constant");
      apb(1'b0, `REG_STATUS, 32'h0000_0000, r, err);
      chk(r[11:4] === 8'h00, "not idle on first channel");
      apb(1'b0, 12'h010, 32'h0000_0000, r, err);
      chk(err === 1'b1 && r === 32'h0000_0000, "unmapped read");
   endtask

   task automatic full_scan(input logic [5:0] len, input logic [15:0] scans);
      logic [31:0] r;
      logic err;
      logic e0;
      int n;
      e0 = eocFlag;
      convLen <= len;
      i_adc_far_side.fifoMem.delete();
      apb(1'b1, `REG_CTRL, 32'h0000_0001, r, err);
      n = 0;
      while (eocFlag === e0 && n < 5000) begin
         @(posedge sys_clk);
         n++;
      end
      chk(eocFlag === ~e0, "completion flag stuck");
      chk(ledSideA === eocFlag && ledSideB === ~eocFlag, "led sides");
      chk(i_adc_far_side.fifoMem.size() == 32, "stored byte count");
      for (int c = 0; c < 16; c++) begin
         chk(i_adc_far_side.fifoMem[2 * c] === {4'hA, c[3:0]}, "high byte");
         chk(i_adc_far_side.fifoMem[2 * c + 1] === {4'h5, ~c[3:0]}, "low byte");
      end
      chk(channelSel === 4'h0, "channel not cleared");
      repeat (60) begin
         @(posedge sys_clk);
         chk(convertStart === 1'b0, "not idle after scan");
      end
      apb(1'b0, `REG_SCANS, 32'h0000_0000, r, err);
      chk(r[15:0] === scans, "scan count");
   endtask

   task automatic reset_abort();
      logic [31:0] r;
      logic err;
      int n;
      convLen <= 6'h04;
      apb(1'b1, `REG_CTRL, 32'h0000_0001, r, err);
      n = 0;
      while (channelSel !== 4'h3 && n < 2000) begin
         @(posedge sys_clk);
         n++;
      end
      n = 0;
      while (converter_busy !== 1'b1 && n < 200) begin
         @(posedge sys_clk);
         n++;
      end
      // Freeze while the converter finishes: nothing may move
      clkEn <= 1'b0;
      repeat (20) begin
         @(posedge sys_clk);
         chk(channelSel === 4'h3 && result_fifo_write === 1'b0, "state moved while frozen");
      end
      clkEn <= 1'b1;
      apb(1'b1, `REG_CTRL, 32'h0000_0001, r, err);
      apb(1'b0, `REG_STATUS, 32'h0000_0000, r, err);
      chk(r[0] === 1'b1 && r[1] === 1'b1, "start not latched during scan");
      apb(1'b1, `REG_CTRL, 32'h0000_0002, r, err);
      apb(1'b0, `REG_STATUS, 32'h0000_0000, r, err);
      chk(r[0] === 1'b0, "latch not cleared");
      do_reset();
      chk(channelSel === 4'h0 && eocFlag === 1'b0, "reset left scan state");
      repeat (60) begin
         @(posedge sys_clk);
         chk(convertStart === 1'b0, "scan resumed after reset");
      end
      apb(1'b0, `REG_STATUS, 32'h0000_0000, r, err);
      chk(r[11:8] === 4'h0 && r[1] === 1'b0, "not idle after reset");
   endtask

   // ------------------------------
   // Clock, sequence, watchdog
   // ------------------------------
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end

   initial begin
      repeat (20000) @(posedge sys_clk);
      badCount++;
      stop_test();
   end

   initial begin
      rst_b = 1'b0;
      clkEn = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      convLen = 6'h02;
      do_reset();
      reset_values();
      full_scan(6'h02, 16'h0001);
      full_scan(6'h1E, 16'h0002);
      reset_abort();
      full_scan(6'h05, 16'h0001);
      stop_test();
   end
endmodule // tb
